//--- rtl/wpra_core.sv
/*
  Read request interpreter with 16/32-bit parameter access units.
  Assumes a byte stream in (valid only, one byte per pulse), a frame end
  pulse from the framing layer, a parameter store answering one cycle
  after a lookup, and a byte sink with valid/ready.
*/
`timescale 1ns/1ps
// How it works
// - Address bit 15 clear selects 16-bit units, set selects 32-bit units.
// - Lower fifteen address bits give the first parameter's index in both modes.
// - In 32-bit mode an odd register count gets an exception reply.
// - Each 32-bit parameter takes two register slots for counting; its index steps by one.
// - Request is address, command, start address, count, check code.
// - Good reply echoes address and command, byte count, data, check code.
// - In 32-bit mode every parameter returns as a 32-bit unit.
// - 32-bit parameter in 16-bit mode returns low half, no saturation.
// - 16-bit parameter, top bit clear, in 32-bit mode gets zero upper half.
// - Top bit set: signed fills ones, unsigned class fills zeros.
// - Matching lengths return the stored value unchanged.
// - Each parameter has a signed or unsigned class and 16/32-bit width.
// - Bad command or count gets an exception reply instead of data; a missing parameter's exception follows the bytes already sent.
module wpra_core import wpra_pkg::*; #(
  parameter logic [7:0] SLAVE_ADDR = 8'h05,
  parameter int IDX_W = 15
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_end_i,
  output logic prm_req_o,
  output logic [IDX_W-1:0] prm_idx_o,
  input wire logic [31:0] prm_value_i,
  input wire logic prm_wide_i,
  input wire logic prm_signed_i,
  input wire logic prm_exists_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i
);
  // ******************************************************************
  // State record
  // ******************************************************************
  typedef struct packed {
    wpra_state_e st;
    logic [63:0] req;
    logic [3:0] nrx;
    logic [15:0] crc;
    logic wide;
    logic [14:0] idx;
    logic [15:0] left;
    logic [39:0] sh;
    logic [2:0] nout;
    logic [1:0] phase;
  } wpra_s;

  wpra_s r;
  wpra_s next_r;

  logic [7:0] b_cmd;
  logic [15:0] f_addr;
  logic [15:0] f_cnt;
  logic [15:0] f_crc;
  logic [15:0] units;
  logic [31:0] ext;
  logic [7:0] tx_byte;
  logic frame_ok;
  logic count_bad;
  logic take_byte;
  logic unit_done;

  // ******************************************************************
  // Field decode and length adaptation
  // ******************************************************************
  always_comb begin
    b_cmd = r.req[55:48];
    f_addr = r.req[47:32];
    f_cnt = r.req[31:16];
    f_crc = {r.req[7:0], r.req[15:8]};
    units = f_addr[WPRA_MODE_BIT] ? {1'b0, f_cnt[15:1]} : f_cnt;
    // Length adaptation of the stored value
    if (r.wide) begin
      if (prm_wide_i) begin
        ext = prm_value_i;
      end else if (prm_value_i[15] && prm_signed_i) begin
        ext = {16'hffff, prm_value_i[15:0]};
      end else begin
        ext = {16'h0000, prm_value_i[15:0]};
      end
    end else begin
      ext = {16'h0000, prm_value_i[15:0]};
    end
    tx_byte = r.sh[39:32];
    // Length, check code and slave address must all match
    frame_ok = (r.nrx == 4'(WPRA_REQ_LEN)) && (r.crc == f_crc)
               && (r.req[63:56] == SLAVE_ADDR);
    // Odd count in 32-bit mode, no units, or over the limit
    count_bad = (f_addr[WPRA_MODE_BIT] && f_cnt[0])
                || (units == 16'h0000)
                || (f_cnt > WPRA_MAX_REGS);
    take_byte = (r.st == WPRA_SEND) && tx_ready_i;
    unit_done = (r.nout == 3'd1);
  end

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    next_r = r;
    unique case (r.st)
      WPRA_IDLE, WPRA_RECV: begin
        if (rx_valid_i) begin
          next_r.st = WPRA_RECV;
          if (r.nrx < 4'(WPRA_REQ_LEN)) begin
            next_r.req = {r.req[55:0], rx_data_i};
            if (r.nrx < 4'(WPRA_REQ_LEN - 2)) begin
              next_r.crc = wpra_crc_byte(r.crc, rx_data_i);
            end
          end
          next_r.nrx = (r.nrx == 4'hf) ? r.nrx : r.nrx + 4'h1;
        end
        if (rx_end_i) begin
          next_r.st = WPRA_CHECK;
        end
      end
      WPRA_CHECK: begin
        next_r.st = WPRA_IDLE;
        next_r.nrx = 4'h0;
        next_r.crc = WPRA_CRC_INIT;
        next_r.wide = f_addr[WPRA_MODE_BIT];
        next_r.idx = f_addr[14:0];
        next_r.left = units;
        next_r.phase = 2'd0;
        // Wrong length, checksum or foreign address: silent drop
        if (frame_ok) begin
          next_r.st = WPRA_SEND;
          next_r.nout = 3'd3;
          if (b_cmd != WPRA_CMD_READ) begin
            next_r.sh = {SLAVE_ADDR, b_cmd | WPRA_EXC_FLAG, WPRA_EXC_ILLEGAL_FUNC, 16'h0000};
            next_r.phase = 2'd3;
          end else if (count_bad) begin
            next_r.sh = {SLAVE_ADDR, b_cmd | WPRA_EXC_FLAG, WPRA_EXC_ILLEGAL_VALUE,
                         16'h0000};
            next_r.phase = 2'd3;
          end else begin
            next_r.sh = {SLAVE_ADDR, b_cmd, f_cnt[6:0], 1'b0, 16'h0000};
            next_r.phase = 2'd1;
          end
          next_r.crc = WPRA_CRC_INIT;
        end
      end
      WPRA_FETCH: begin
        // Store answers this cycle for the index sent last cycle
        if (!prm_exists_i) begin
          next_r.sh = {SLAVE_ADDR, WPRA_CMD_READ | WPRA_EXC_FLAG, WPRA_EXC_ILLEGAL_ADDR,
                       16'h0000};
          next_r.nout = 3'd3;
          next_r.phase = 2'd3;
          next_r.crc = WPRA_CRC_INIT;
        end else if (r.wide) begin
          next_r.sh = {ext, 8'h00};
          next_r.nout = 3'd4;
        end else begin
          next_r.sh = {ext[15:0], 24'h000000};
          next_r.nout = 3'd2;
        end
        next_r.idx = r.idx + 15'h0001;
        next_r.left = r.left - 16'h0001;
        next_r.st = WPRA_SEND;
      end
      // Each accepted byte shifts out; the check code is not fed back into itself
      WPRA_SEND: begin
        if (tx_ready_i) begin
          next_r.sh = {r.sh[31:0], 8'h00};
          next_r.nout = r.nout - 3'd1;
          if (r.phase != 2'd2) begin
            next_r.crc = wpra_crc_byte(r.crc, tx_byte);
          end
          if (r.nout == 3'd1) begin
            if (r.phase == 2'd2) begin
              next_r.st = WPRA_IDLE;
              next_r.crc = WPRA_CRC_INIT;
            end else if (r.phase == 2'd1 && r.left != 16'h0000) begin
              next_r.st = WPRA_FETCH;
            end else begin
              // Check code goes out low byte first
              next_r.sh = {next_r.crc[7:0], next_r.crc[15:8], 24'h000000};
              next_r.nout = 3'd2;
              next_r.phase = 2'd2;
            end
          end
        end
      end
      default: next_r.st = WPRA_IDLE;
    endcase
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      r <= '{st: WPRA_IDLE, crc: WPRA_CRC_INIT, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ******************************************************************
  // Lookup and reply ports
  // ******************************************************************
  assign prm_req_o = take_byte && unit_done
                     && r.phase == 2'd1 && r.left != 16'h0000;
  assign prm_idx_o = IDX_W'(r.idx);
  assign tx_valid_o = (r.st == WPRA_SEND);
  assign tx_data_o = tx_byte;
  assign tx_last_o = (r.st == WPRA_SEND) && r.phase == 2'd2 && r.nout == 3'd1;
endmodule : wpra_core

//--- rtl/wpra_pkg.sv
/*
  Package for the wide parameter read access block: frame layout, command
  codes, exception codes and state encoding.
  Assumes one 20 MHz clock and a byte stream framing layer outside.
*/
package wpra_pkg;
  // ******************************************************************
  // Frame layout
  // ******************************************************************
  localparam logic [7:0] WPRA_CMD_READ = 8'h03;
  localparam logic [7:0] WPRA_EXC_FLAG = 8'h80;
  localparam logic [7:0] WPRA_EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] WPRA_EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] WPRA_EXC_ILLEGAL_VALUE = 8'h03;
  localparam int WPRA_REQ_LEN = 8;
  localparam int WPRA_MODE_BIT = 15;
  localparam logic [15:0] WPRA_CRC_INIT = 16'hffff;
  localparam logic [15:0] WPRA_CRC_POLY = 16'ha001;
  localparam logic [15:0] WPRA_MAX_REGS = 16'h007d;
  localparam logic [31:0] WPRA_CLK_HZ = 32'd20000000;

  // ******************************************************************
  // States
  // ******************************************************************
  typedef enum logic [4:0] {
    WPRA_IDLE = 5'b00001,
    WPRA_RECV = 5'b00010,
    WPRA_CHECK = 5'b00100,
    WPRA_FETCH = 5'b01000,
    WPRA_SEND = 5'b10000
  } wpra_state_e;

  function automatic logic [15:0] wpra_crc_byte(input logic [15:0] crc,
                                                input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ WPRA_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : wpra_crc_byte
endpackage : wpra_pkg

//--- verif/wpra_store.sv
/* Parameter store model with a fixed table.
   Assumes lookups as pulses; the answer is held from the next cycle. */
`timescale 1ns/1ps
package wpra_tbp;
  // Gives {wide, signed, value}; narrow entries carry junk above bit 15
  function automatic logic [33:0] wpra_entry(input logic [14:0] idx);
    case (idx[2:0])
      3'h0: return {2'b01, 32'h5a5a1194};
      3'h1: return {2'b11, 32'h0000fe0c};
      3'h2: return {2'b01, 32'ha5a5fe0c};
      3'h3: return {2'b11, 32'h00001388};
      3'h4: return {2'b11, 32'h000186a0};
      3'h5: return {2'b11, 32'hfffe7960};
      3'h6: return {2'b00, 32'h3c3cffff};
      default: return {2'b10, 32'h80017fff};
    endcase
  endfunction : wpra_entry
endpackage : wpra_tbp

module wpra_store import wpra_tbp::*; (
  input wire logic clock_i,
  input wire logic prm_req_i,
  input wire logic [14:0] prm_idx_i,
  output logic [31:0] prm_value_o,
  output logic prm_wide_o,
  output logic prm_signed_o,
  output logic prm_exists_o
);
  always @(posedge clock_i) begin
    if (prm_req_i) begin
      {prm_wide_o, prm_signed_o, prm_value_o} <= wpra_entry(prm_idx_i);
      prm_exists_o <= (prm_idx_i < 15'h4000);
    end
  end
endmodule : wpra_store

//--- verif/wpra_core_chk.sv
/* Port assertions for the read interpreter.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
module wpra_core_chk #(
  parameter int IDX_W = 15
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic rx_end_i,
  input wire logic prm_req_o,
  input wire logic [IDX_W-1:0] prm_idx_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic seen;
  logic [IDX_W-1:0] last_idx;
  always_ff @(posedge clock_i) begin
    if (!nrst_i || (tx_valid_o && tx_ready_i && tx_last_o)) seen <= 1'b0;
    else if (prm_req_o) seen <= 1'b1;
    if (prm_req_o) last_idx <= prm_idx_o;
  end
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |=>
    !tx_valid_o && !prm_req_o && prm_idx_o == '0) else $error("outputs busy after reset");
  a_data_stands: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o)) else $error("byte withdrawn");
  a_last_valid: assert property (tx_last_o |-> tx_valid_o) else $error("last without valid");
  a_last_ends: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o)
    else $error("bytes after last");
  a_req_pulse: assert property (prm_req_o |=> !prm_req_o) else $error("lookup too long");
  a_no_early: assert property (rx_end_i && !tx_valid_o |=> !tx_valid_o && !prm_req_o)
    else $error("reply too early");
  a_idx_step: assert property (prm_req_o && seen |-> prm_idx_o == IDX_W'(last_idx + 1))
    else $error("index step wrong");
  a_req_accept: assert property (prm_req_o |-> tx_valid_o && tx_ready_i ##1 !tx_valid_o)
    else $error("lookup outside an accepted byte");
  c_last: cover property (tx_valid_o && tx_ready_i && tx_last_o);
  c_req: cover property (prm_req_o);
  c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule : wpra_core_chk

bind wpra_core wpra_core_chk #(.IDX_W(IDX_W)) wpra_core_chk_inst (.clock_i(clock_i),
  .nrst_i(nrst_i), .rx_end_i(rx_end_i), .prm_req_o(prm_req_o), .prm_idx_o(prm_idx_o),
  .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
  .tx_ready_i(tx_ready_i));

//--- verif/testbench.sv
/* Self-checking bench for the read interpreter.
   Assumes the store model and checker files compile before it. */
`timescale 1ns/1ps
module testbench import wpra_pkg::*, wpra_tbp::*;;
  logic clock_i = 0, nrst_i = 0, rx_valid_i = 0, rx_end_i = 0, tx_ready_i = 0;
  logic [7:0] rx_data_i = '0;
  logic prm_req_o, prm_wide_i, prm_signed_i, prm_exists_i, tx_valid_o, tx_last_o;
  logic [14:0] prm_idx_o;
  logic [31:0] prm_value_i;
  logic [7:0] tx_data_o;
  logic [8:0] exp_q[$];
  logic [15:0] crc;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  always #25 clock_i = ~clock_i;
  wpra_core wpra_core_inst (.clock_i(clock_i), .nrst_i(nrst_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_end_i(rx_end_i), .prm_req_o(prm_req_o),
    .prm_idx_o(prm_idx_o), .prm_value_i(prm_value_i), .prm_wide_i(prm_wide_i),
    .prm_signed_i(prm_signed_i), .prm_exists_i(prm_exists_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i));
  wpra_store wpra_store_inst (.clock_i(clock_i), .prm_req_i(prm_req_o),
    .prm_idx_i(prm_idx_o), .prm_value_o(prm_value_i), .prm_wide_o(prm_wide_i),
    .prm_signed_o(prm_signed_i), .prm_exists_o(prm_exists_i));
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction : crc_step
  task fail(input string m);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail
  task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task put(input logic [7:0] b, input logic last);
    exp_q.push_back({last, b});
    crc = crc_step(crc, b);
  endtask : put
  task expect_reply(input logic [7:0] cmd, input logic [15:0] start, input logic [15:0] cnt);
    logic [33:0] e;
    logic [15:0] c;
    crc = 16'hffff;
    put(8'h05, 0);
    if (cmd != WPRA_CMD_READ) begin
      put(cmd | WPRA_EXC_FLAG, 0);
      put(WPRA_EXC_ILLEGAL_FUNC, 0);
    end else if ((start[15] && cnt[0]) || cnt == 0 || cnt > WPRA_MAX_REGS) begin
      put(cmd | WPRA_EXC_FLAG, 0);
      put(WPRA_EXC_ILLEGAL_VALUE, 0);
    end else begin
      put(cmd, 0);
      put(8'(cnt * 2), 0);
      for (int i = 0; i < (start[15] ? cnt / 2 : cnt); i++) begin
        if (start[14:0] + 15'(i) >= 15'h4000) begin
          crc = 16'hffff;
          put(8'h05, 0);
          put(cmd | WPRA_EXC_FLAG, 0);
          put(WPRA_EXC_ILLEGAL_ADDR, 0);
          break;
        end
        e = wpra_entry(start[14:0] + 15'(i));
        if (start[15]) begin
          if (!e[33]) e[31:16] = (e[32] && e[15]) ? 16'hffff : 16'h0000;
          put(e[31:24], 0);
          put(e[23:16], 0);
        end
        put(e[15:8], 0);
        put(e[7:0], 0);
      end
    end
    c = crc;
    put(c[7:0], 0);
    put(c[15:8], 1);
  endtask : expect_reply
  task send(input logic [7:0] sa, cmd, input logic [15:0] start, cnt, input logic bad);
    logic [7:0] f[8];
    logic [15:0] c;
    f = '{sa, cmd, start[15:8], start[7:0], cnt[15:8], cnt[7:0], 8'h00, 8'h00};
    c = 16'hffff;
    for (int i = 0; i < 6; i++) c = crc_step(c, f[i]);
    c = c ^ {15'h0000, bad};
    f[6] = c[7:0];
    f[7] = c[15:8];
    if (sa == 8'h05 && !bad) expect_reply(cmd, start, cnt);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i);
      #1 rx_valid_i = 1;
      rx_data_i = f[i];
    end
    @(posedge clock_i);
    #1 rx_valid_i = 0;
    rx_end_i = 1;
    @(posedge clock_i);
    #1 rx_end_i = 0;
    for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge clock_i);
    repeat (6) @(posedge clock_i);
    #1;
    if (exp_q.size() != 0) fail("reply incomplete");
    exp_q.delete();
  endtask : send
  always @(posedge clock_i) begin
    if (nrst_i && tx_valid_o && tx_ready_i) begin
      check_count++;
      if (exp_q.size() == 0) fail("unexpected reply byte");
      else if ({tx_last_o, tx_data_o} !== exp_q.pop_front()) fail("reply byte differs");
    end
    if (++cycles > 20000) begin
      fail("timeout");
      close_out;
    end
  end
  initial begin
    void'($urandom(32'h3bd4));
    fork
      forever begin
        @(posedge clock_i);
        #1 tx_ready_i = ($urandom_range(0, 3) != 0);
      end
    join_none
    repeat (4) @(posedge clock_i);
    #1 nrst_i = 1;
    send(8'h05, WPRA_CMD_READ, 16'h0000, 16'h0008, 0);
    send(8'h05, WPRA_CMD_READ, 16'h8000, 16'h0010, 0);
    send(8'h05, WPRA_CMD_READ, 16'h8003, 16'h0007, 0);
    send(8'h05, WPRA_CMD_READ, 16'h8000, 16'h0080, 0);
    send(8'h05, 8'h04, 16'h0001, 16'h0002, 0);
    send(8'h05, WPRA_CMD_READ, 16'h0002, 16'h0001, 1);
    send(8'h06, WPRA_CMD_READ, 16'h0002, 16'h0001, 0);
    send(8'h05, WPRA_CMD_READ, 16'h3fff, 16'h0002, 0);
    for (int i = 0; i < 12; i++) send(8'h05, WPRA_CMD_READ, {1'($urandom),
      15'($urandom_range(0, 2047))}, 16'($urandom_range(1, 8)) * 16'h0002, 0);
    close_out;
  end
endmodule : testbench
